// file: design/bcn_pkg.sv
// Purpose : shared types, opcodes and helpers of the bcd/binary convert and negate unit
// Assumes : one 10 MHz clock, synchronous active-low reset
// Notes   : helpers are also used by the embedded checks
package bcn_pkg;

	// ---------------------------------------------------------------
	// widths and limits
	// ---------------------------------------------------------------
	localparam int          WORD_W        = 16;
	localparam int          DIGITS_DWORD  = 8;
	localparam int          BCD_LIMIT_W   = 16'h270F;     // 9999
	localparam logic [31:0] BCD_LIMIT_DW  = 32'h05F5E0FF; // 9999 9999
	localparam logic [15:0] NEGATE_ONE_LSB = 16'h0001;
	localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0]  DABBLE_THRESH = 4'h5;
	localparam logic [3:0]  DABBLE_ADD    = 4'h3;

	// ---------------------------------------------------------------
	// operations
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_DECIMAL_TO_HEX_WORD  = 3'h0,
		OP_DECIMAL_TO_HEX_DWORD = 3'h1,
		OP_HEX_TO_DECIMAL_WORD  = 3'h2,
		OP_HEX_TO_DECIMAL_DWORD = 3'h3,
		OP_TWOS_COMPLEMENT_WORD = 3'h4
	} bcn_op_t;

	// request from the sequencer: first word is the low half
	typedef struct packed {
		logic        valid;
		bcn_op_t     op;
		logic [15:0] src_lo;
		logic [15:0] src_hi;
	} bcn_req_t;

	// answer to the sequencer
	typedef struct packed {
		logic        done;
		logic        write_en;
		logic        two_words;
		logic [15:0] res_lo;
		logic [15:0] res_hi;
		logic        error_flag;
		logic        zero_flag;
		logic        sign_flag;
	} bcn_res_t;

	// all state of the core
	typedef struct packed {
		bcn_res_t res;
	} bcn_state_t;

	// every nibble a decimal digit
	function automatic logic bcn_bcd_ok(input logic [31:0] v);
		logic ok;
		ok = 1'b1;
		for (int i = 0; i < DIGITS_DWORD; i++) begin
			if (v[i*4 +: 4] > BCD_MAX_DIGIT) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : bcn_bcd_ok

	// weighted digit sum, most significant digit first
	function automatic logic [31:0] bcn_bcd_value(input logic [31:0] v);
		logic [31:0] acc;
		acc = 32'h0;
		for (int i = DIGITS_DWORD - 1; i >= 0; i--) begin
			acc = 32'((acc << 3) + (acc << 1) + {28'h0, v[i*4 +: 4]});
		end
		return acc;
	endfunction : bcn_bcd_value

endpackage : bcn_pkg

// file: design/bcn_dabble.sv
// Purpose : combinational 32-bit binary to eight bcd digits (shift and add three)
// Assumes : input at most 9999 9999, larger values give meaningless digits
// Notes   : caller flags out-of-range inputs and suppresses the write
`timescale 1ns/1ps
module bcn_dabble
	import bcn_pkg::*;
(
	input  wire logic [31:0] binary_in,
	output logic      [31:0] bcd_out
);

	// ---------------------------------------------------------------
	// double dabble
	// ---------------------------------------------------------------
	// one pass per input bit; chosen over a divider chain for small area
	always_comb begin
		logic [63:0] sh;
		sh = {32'h0, binary_in};
		for (int b = 0; b < 32; b++) begin
			for (int d = 0; d < DIGITS_DWORD; d++) begin
				if (sh[32 + d*4 +: 4] >= DABBLE_THRESH) begin
					sh[32 + d*4 +: 4] = sh[32 + d*4 +: 4] + DABBLE_ADD;
				end
			end
			sh = sh << 1;
		end
		bcd_out = sh[63:32];
	end

endmodule : bcn_dabble

// file: design/bcn_convert.sv
// Purpose : bcd/binary conversion and word negate datapath for the controller cpu
// Assumes : sequencer presents one request per cycle at most, unit is always ready
// Notes   : answer is registered and appears one clock after the request
`timescale 1ns/1ps
// Contract
// RULE1 - word decimal-to-hex gives binary of four digits
// RULE2 - word decimal-to-hex errors on any non-decimal nibble
// RULE3 - dword decimal-to-hex gives 32-bit binary, two words
// RULE4 - dword decimal-to-hex errors on any non-decimal nibble
// RULE5 - word hex-to-decimal gives four bcd digits
// RULE6 - word hex-to-decimal errors above 270F hex
// RULE7 - dword hex-to-decimal gives eight bcd digits
// RULE8 - dword hex-to-decimal errors above 05F5E0FF hex
// RULE9 - conversions set zero flag for zero result
// RULE10 - negate inverts source and adds one
// RULE11 - negate of 8000 gives 8000, no error
// RULE12 - negate copies result bit 15 to sign
// RULE13 - negate sets zero on zero, error always clear
// RULE14 - first word low half, next word high
// RULE15 - decimal-to-hex clears sign; error suppresses write
module bcn_convert
	import bcn_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire bcn_pkg::bcn_req_t req,
	output bcn_pkg::bcn_res_t     res
);
	import bcn_pkg::*;

	bcn_state_t  st_r;
	bcn_state_t  st_nxt;
	logic [31:0] dab_in;
	logic [31:0] dab_out;

	// ---------------------------------------------------------------
	// shared binary to bcd converter
	// ---------------------------------------------------------------
	// one converter serves both widths; the word form zero-extends
	assign dab_in = (req.op == OP_HEX_TO_DECIMAL_DWORD) ? {req.src_hi, req.src_lo}
	                                                    : {16'h0, req.src_lo};

	bcn_dabble u_dabble (
		.binary_in (dab_in),
		.bcd_out (dab_out)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [31:0] val;
		logic        err;
		logic        two;
		logic        sgn;
		val    = 32'h0;
		err    = 1'b0;
		two    = 1'b0;
		sgn    = 1'b0;
		st_nxt = st_r;
		st_nxt.res.done     = 1'b0;
		st_nxt.res.write_en = 1'b0;
		if (req.valid) begin
			case (req.op)
				OP_DECIMAL_TO_HEX_WORD: begin
					val = bcn_bcd_value({16'h0, req.src_lo});          // [RULE1]
					err = !bcn_bcd_ok({16'h0, req.src_lo});           // [RULE2]
				end
				OP_DECIMAL_TO_HEX_DWORD: begin
					val = bcn_bcd_value({req.src_hi, req.src_lo});     // [RULE3] [RULE14]
					err = !bcn_bcd_ok({req.src_hi, req.src_lo});      // [RULE4]
					two = 1'b1;
				end
				OP_HEX_TO_DECIMAL_WORD: begin
					val = dab_out;                                     // [RULE5]
					err = req.src_lo > 16'(BCD_LIMIT_W);               // [RULE6]
				end
				OP_HEX_TO_DECIMAL_DWORD: begin
					val = dab_out;                                     // [RULE7] [RULE14]
					err = {req.src_hi, req.src_lo} > BCD_LIMIT_DW;     // [RULE8]
					two = 1'b1;
				end
				OP_TWOS_COMPLEMENT_WORD: begin
					// 8000 wraps onto itself, no overflow reported
					val = {16'h0, ~req.src_lo + NEGATE_ONE_LSB};       // [RULE10] [RULE11]
					sgn = val[15];                                     // [RULE12]
				end
				default: begin
					err = 1'b1;
				end
			endcase
			st_nxt.res.done       = 1'b1;
			st_nxt.res.two_words  = two;
			st_nxt.res.error_flag = err;                               // [RULE13]
			st_nxt.res.sign_flag  = sgn && !err;                       // [RULE15]
			// zero flag judged on the written width only
			st_nxt.res.zero_flag  = !err && (two ? (val == 32'h0)
			                                     : (val[15:0] == 16'h0)); // [RULE9] [RULE13]
			// a failed conversion leaves the result words untouched
			if (!err) begin                                            // [RULE15]
				st_nxt.res.write_en = 1'b1;
				st_nxt.res.res_lo   = val[15:0];
				if (two) begin
					st_nxt.res.res_hi = val[31:16];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign res = st_r.res;

	// ---------------------------------------------------------------
	// embedded checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_dhw_value: assert property ( // [RULE1]
		req.valid && req.op == OP_DECIMAL_TO_HEX_WORD && bcn_bcd_ok({16'h0, req.src_lo})
		|=> res.write_en && res.res_lo == 16'(bcn_bcd_value({16'h0, $past(req.src_lo)})))
		else $error("word decimal-to-hex value wrong");

	chk_dhw_error: assert property ( // [RULE2]
		req.valid && req.op == OP_DECIMAL_TO_HEX_WORD
		|=> res.done && res.error_flag == !bcn_bcd_ok({16'h0, $past(req.src_lo)}))
		else $error("word decimal-to-hex error flag wrong");

	chk_dhd_value: assert property ( // [RULE3]
		req.valid && req.op == OP_DECIMAL_TO_HEX_DWORD && bcn_bcd_ok({req.src_hi, req.src_lo})
		|=> res.two_words && {res.res_hi, res.res_lo}
		    == bcn_bcd_value({$past(req.src_hi), $past(req.src_lo)}))
		else $error("dword decimal-to-hex value wrong");

	chk_dhd_error: assert property ( // [RULE4]
		req.valid && req.op == OP_DECIMAL_TO_HEX_DWORD
		|=> res.error_flag == !bcn_bcd_ok({$past(req.src_hi), $past(req.src_lo)})
		    && !res.sign_flag)
		else $error("dword decimal-to-hex flags wrong");

	chk_hdw_value: assert property ( // [RULE5]
		req.valid && req.op == OP_HEX_TO_DECIMAL_WORD && req.src_lo <= 16'(BCD_LIMIT_W)
		|=> bcn_bcd_ok({16'h0, res.res_lo})
		    && bcn_bcd_value({16'h0, res.res_lo}) == {16'h0, $past(req.src_lo)})
		else $error("word hex-to-decimal value wrong");

	chk_hdw_error: assert property ( // [RULE6]
		req.valid && req.op == OP_HEX_TO_DECIMAL_WORD
		|=> res.error_flag == ($past(req.src_lo) > 16'(BCD_LIMIT_W)))
		else $error("word hex-to-decimal error flag wrong");

	chk_hdd_value: assert property ( // [RULE7]
		req.valid && req.op == OP_HEX_TO_DECIMAL_DWORD
		&& {req.src_hi, req.src_lo} <= BCD_LIMIT_DW
		|=> bcn_bcd_value({res.res_hi, res.res_lo}) == {$past(req.src_hi), $past(req.src_lo)})
		else $error("dword hex-to-decimal value wrong");

	chk_hdd_error: assert property ( // [RULE8]
		req.valid && req.op == OP_HEX_TO_DECIMAL_DWORD
		|=> res.error_flag == ({$past(req.src_hi), $past(req.src_lo)} > BCD_LIMIT_DW))
		else $error("dword hex-to-decimal error flag wrong");

	chk_zero_flag: assert property ( // [RULE9]
		res.done && res.write_en
		|-> res.zero_flag == (res.two_words ? ({res.res_hi, res.res_lo} == 32'h0)
		                                    : (res.res_lo == 16'h0)))
		else $error("zero flag does not match result");

	chk_negate_value: assert property ( // [RULE10] [RULE11]
		req.valid && req.op == OP_TWOS_COMPLEMENT_WORD
		|=> res.write_en && res.res_lo == 16'(16'h0 - $past(req.src_lo)))
		else $error("negate result wrong");

	chk_negate_flags: assert property ( // [RULE12] [RULE13]
		req.valid && req.op == OP_TWOS_COMPLEMENT_WORD
		|=> !res.error_flag && res.sign_flag == res.res_lo[15]
		    && res.zero_flag == (res.res_lo == 16'h0))
		else $error("negate flags wrong");

	chk_err_nowrite: assert property ( // [RULE15]
		res.done && res.error_flag
		|-> !res.write_en && $stable(res.res_lo) && $stable(res.res_hi))
		else $error("result written despite error");

	// ---------------------------------------------------------------
	// checks shared by several operations, and corner cases
	// ---------------------------------------------------------------
	// word operations must leave the high result word alone
	chk_word_keeps_hi: assert property ( // [RULE14]
		req.valid && req.op != OP_DECIMAL_TO_HEX_DWORD && req.op != OP_HEX_TO_DECIMAL_DWORD
		|=> $stable(res.res_hi))
		else $error("word operation changed the high result word");

	// the write strobe is exactly a clean answer
	chk_write_gate: assert property ( // [RULE15]
		res.write_en == (res.done && !res.error_flag))
		else $error("write strobe disagrees with the error flag");

	// an undefined opcode answers with an error and no write
	chk_bad_opcode: assert property ( // [RULE15]
		req.valid && req.op > OP_TWOS_COMPLEMENT_WORD
		|=> res.done && res.error_flag && !res.write_en && !res.zero_flag && !res.sign_flag)
		else $error("undefined opcode not rejected");

	// the most negative word maps onto itself, negative and error-free
	chk_negate_min: assert property ( // [RULE11]
		req.valid && req.op == OP_TWOS_COMPLEMENT_WORD && req.src_lo == 16'h8000
		|=> res.write_en && res.res_lo == 16'h8000 && !res.error_flag && res.sign_flag)
		else $error("negate of the most negative word wrong");

	cov_negate_min: cover property (
		req.valid && req.op == OP_TWOS_COMPLEMENT_WORD && req.src_lo == 16'h8000 ##1 res.done);
	cov_dword_err: cover property (
		req.valid && req.op == OP_HEX_TO_DECIMAL_DWORD ##1 res.error_flag);
	cov_dword_zero: cover property (
		req.valid && req.op == OP_DECIMAL_TO_HEX_DWORD ##1 res.zero_flag);
	cov_back_to_back: cover property (req.valid ##1 req.valid ##1 res.done);

endmodule : bcn_convert

// file: bench/bcn_seq_model.sv
// Purpose : instruction sequencer model feeding requests to the convert unit
// Assumes : requests queued by the bench, issued at the falling edge
// Notes   : slow mode inserts random idle cycles between requests
`timescale 1ns/1ps
module bcn_seq_model
	import bcn_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      reset_n,
	input  wire logic      slow,
	output bcn_pkg::bcn_req_t req
);
	import bcn_pkg::*;
	bcn_req_t q[$];

	// queue one request from the bench
	task automatic push(input bcn_req_t r);
		q.push_back(r);
	endtask : push

	// one request per cycle at most, none while reset is seen low
	always @(negedge clk) begin
		if (!reset_n) begin
			req <= '0;
		end else if (q.size() > 0 && !(slow && $urandom_range(1, 0) == 1)) begin
			req <= q.pop_front();
		end else begin
			// idle: operands scrambled so stale words are never trusted
			req <= {1'b0, req.op, ~req.src_lo, ~req.src_hi};
		end
	end
endmodule : bcn_seq_model

// file: bench/bcd_binary_convert_negate_bench.sv
// Purpose : self-checking bench of the convert and negate unit
// Assumes : answer one clock after each request, state held otherwise
// Notes   : full result state compared at every falling edge
`timescale 1ns/1ps
module bcd_binary_convert_negate_bench;
	import bcn_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        slow = 1'b0;
	bcn_req_t    req;
	bcn_res_t    res;
	logic        taken, e_two, e_err, e_zero, e_sign;
	logic [15:0] e_lo, e_hi, lo, hi;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles = 0;
	logic [31:0] seed;
	bcn_op_t     op;
	// op, first word, second word
	logic [34:0] tbl [14] = '{{3'h0, 16'h1234, 16'h0000}, {3'h0, 16'h00A0, 16'h0000},
		{3'h0, 16'h0000, 16'h0000}, {3'h1, 16'h9999, 16'h9999}, {3'h1, 16'h0000, 16'hF000},
		{3'h2, 16'h270F, 16'h0000}, {3'h2, 16'h2710, 16'h0000}, {3'h3, 16'hE0FF, 16'h05F5},
		{3'h3, 16'hE100, 16'h05F5}, {3'h3, 16'h0000, 16'h0000}, {3'h4, 16'h8000, 16'h0000},
		{3'h4, 16'h0000, 16'h0000}, {3'h4, 16'h0001, 16'h0000}, {3'h5, 16'h0001, 16'h0000}};

	always #50 clk = ~clk;

	bcn_seq_model bcn_seq_model_inst (.clk(clk), .reset_n(reset_n), .slow(slow), .req(req));
	bcn_convert bcn_convert_inst (.clk(clk), .reset_n(reset_n), .req(req), .res(res));

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ---------------------------------------------------------------
	// reference model of one request
	// ---------------------------------------------------------------
	task automatic calc(input bcn_req_t r);
		logic        two;
		logic        err;
		logic [31:0] v;
		logic [31:0] acc;
		two = (r.op == OP_DECIMAL_TO_HEX_DWORD || r.op == OP_HEX_TO_DECIMAL_DWORD);
		v = two ? {r.src_hi, r.src_lo} : {16'h0, r.src_lo};
		err = 1'b0;
		acc = 32'h0;
		case (r.op)
			OP_DECIMAL_TO_HEX_WORD, OP_DECIMAL_TO_HEX_DWORD: begin
				for (int i = 7; i >= 0; i--) begin
					if (v[i*4 +: 4] > 4'h9) err = 1'b1;
					acc = acc * 10 + 32'(v[i*4 +: 4]);
				end
			end
			OP_HEX_TO_DECIMAL_WORD, OP_HEX_TO_DECIMAL_DWORD: begin
				err = v > (two ? 32'h05F5E0FF : 32'h0000270F);
				for (int i = 0; i < 8; i++) begin
					acc[i*4 +: 4] = 4'(v % 10);
					v = v / 10;
				end
			end
			OP_TWOS_COMPLEMENT_WORD: acc = {16'h0, 16'(~r.src_lo + 16'h1)};
			default: err = 1'b1;
		endcase
		e_two = two;
		e_err = err;
		e_zero = !err && (two ? acc == 32'h0 : acc[15:0] == 16'h0);
		e_sign = !err && r.op == OP_TWOS_COMPLEMENT_WORD && acc[15];
		if (!err) e_lo = acc[15:0];
		if (!err && two) e_hi = acc[31:16];
	endtask : calc

	// model follows each request taken at the rising edge
	always @(posedge clk) begin
		taken = reset_n && req.valid;
		if (!reset_n) {e_two, e_err, e_zero, e_sign, e_lo, e_hi} = '0;
		else if (taken) calc(req);
	end

	// whole answer compared once settled
	always @(negedge clk) begin
		check("done", {31'h0, taken}, {31'h0, res.done});
		check("write_en", {31'h0, taken && !e_err}, {31'h0, res.write_en});
		check("two_words", {31'h0, e_two}, {31'h0, res.two_words});
		check("result_lo", {16'h0, e_lo}, {16'h0, res.res_lo});
		check("result_hi", {16'h0, e_hi}, {16'h0, res.res_hi});
		check("error", {31'h0, e_err}, {31'h0, res.error_flag});
		check("zero", {31'h0, e_zero}, {31'h0, res.zero_flag});
		check("sign", {31'h0, e_sign}, {31'h0, res.sign_flag});
		cycles++;
		if (cycles > 4000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic drain;
		while (bcn_seq_model_inst.q.size() > 0) @(negedge clk);
		repeat (3) @(negedge clk);
	endtask : drain

	initial begin
		seed = $urandom(32'h2AD6);
		repeat (2) @(negedge clk);
		reset_n <= 1'b1;
		// directed boundaries, back to back
		foreach (tbl[i]) bcn_seq_model_inst.push({1'b1, tbl[i]});
		drain();
		slow <= 1'b1;
		// random traffic, decimal digits half of the time
		for (int n = 0; n < 300; n++) begin
			op = bcn_op_t'($urandom_range(4, 0));
			lo = 16'($urandom);
			hi = 16'($urandom);
			if ($urandom_range(1, 0) == 1) begin
				for (int i = 0; i < 4; i++) lo[i*4 +: 4] = 4'($urandom_range(9, 0));
				for (int i = 0; i < 4; i++) hi[i*4 +: 4] = 4'($urandom_range(9, 0));
				if (op == OP_HEX_TO_DECIMAL_DWORD) hi = hi & 16'h07FF;
			end
			bcn_seq_model_inst.push({1'b1, op, lo, hi});
		end
		drain();
		// second reset in mid-run, then work again
		reset_n <= 1'b0;
		@(negedge clk);
		reset_n <= 1'b1;
		bcn_seq_model_inst.push({1'b1, OP_HEX_TO_DECIMAL_WORD, 16'h04D2, 16'h0000});
		bcn_seq_model_inst.push({1'b1, OP_DECIMAL_TO_HEX_DWORD, 16'h0000, 16'h0000});
		drain();
		wrap_up();
	end
endmodule : bcd_binary_convert_negate_bench
